// ---- rtl/pwm_pkg.sv ----
// Purpose: Shared constants for the four-channel pulse width generator.
// Assumes: 25 MHz core clock, APB register access with 32-bit data.
// Notes:   Each channel owns a block of five registers.
package pwm_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned BASE_FINE_NS    = 100000;
	localparam int unsigned BASE_FINE_CYC   = BASE_FINE_NS / (1000000000 / CLK_HZ);
	localparam int unsigned NUM_CH          = 4;

	localparam logic [11:0] OFS_CTRL        = 12'h000;
	localparam logic [11:0] OFS_PERIOD      = 12'h004;
	localparam logic [11:0] OFS_DELAY       = 12'h008;
	localparam logic [11:0] OFS_MINPULSE    = 12'h00C;
	localparam logic [11:0] OFS_OUTVAL      = 12'h010;
	localparam logic [11:0] CH_STRIDE       = 12'h020;

	localparam int unsigned CTRL_GATE_BIT   = 0;
	localparam int unsigned CTRL_BASE_BIT   = 1;
	localparam int unsigned CTRL_FMT_BIT    = 2;
	localparam int unsigned CTRL_STATE_BIT  = 8;
	localparam int unsigned CTRL_CNTOFF_BIT = 9;
	localparam int unsigned CTRL_OUT_BIT    = 10;

	localparam logic [15:0] PERIOD_RST      = 16'h4E20;
	localparam logic [15:0] DELAY_RST       = 16'h0000;
	localparam logic [15:0] MINPULSE_RST    = 16'h0002;
	localparam logic [15:0] OUTVAL_RST      = 16'h0000;
	localparam logic [15:0] PERMIL_FULL     = 16'h03E8;
	localparam logic [15:0] ANALOG_FULL     = 16'h6C00;
	localparam logic [15:0] PERIOD_MIN_FINE = 16'h0004;
	localparam logic [15:0] PERIOD_MIN_MS   = 16'h0001;
	localparam logic [15:0] MINP_MIN_FINE   = 16'h0002;
endpackage

// ---- rtl/pwm_tick_gen.sv ----
// Purpose: Time-base enable pulses at 0.1 ms and 1 ms.
// Assumes: Single core clock.
// Notes:   The 1 ms pulse coincides with every tenth 0.1 ms pulse.
`timescale 1ns/1ps
module pwm_tick_gen (
	input  wire logic core_clk_in,
	input  wire logic reset_n_in,
	output logic      tick_fine_out,
	output logic      tick_ms_out
);
	logic [15:0] cyc_r;
	logic [3:0]  dec_r;

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cyc_r <= 16'h0000;
			dec_r <= 4'h0;
			tick_fine_out <= 1'b0;
			tick_ms_out <= 1'b0;
		end else begin
			tick_fine_out <= 1'b0;
			tick_ms_out <= 1'b0;
			if (cyc_r == 16'(pwm_pkg::BASE_FINE_CYC - 1)) begin
				cyc_r <= 16'h0000;
				tick_fine_out <= 1'b1;
				if (dec_r == 4'h9) begin
					dec_r <= 4'h0;
					tick_ms_out <= 1'b1;
				end else begin
					dec_r <= dec_r + 4'h1;
				end
			end else begin
				cyc_r <= cyc_r + 16'h0001;
			end
		end
	end
endmodule

// ---- rtl/pwm_channel.sv ----
// Purpose: One output channel: on-delay, pulse and pause phases, spike filter.
// Assumes: Settings are stable while the gate is open; tick is one cycle.
// Notes:   Pulse width is computed once per period from the output value.
`timescale 1ns/1ps
module pwm_channel (
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        tick_in,
	input  wire logic        gate_in,
	input  wire logic        fmt_analog_in,
	input  wire logic [15:0] period_in,
	input  wire logic [15:0] delay_in,
	input  wire logic [15:0] min_pulse_in,
	input  wire logic [15:0] out_val_in,
	output logic             pwm_out,
	output logic             running_out
);
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_DELAY = 2'b01, ST_RUN = 2'b11} ch_state_e;

	ch_state_e   state_r;
	logic [15:0] cnt_r;
	logic [15:0] width_r;
	logic [15:0] width_nxt;

	function automatic logic [15:0] pulse_width(input logic [15:0] val, input logic [15:0] per,
			input logic analog, input logic [15:0] minp);
		logic [15:0] full;
		logic [15:0] v;
		logic [31:0] w;
		full = analog ? pwm_pkg::ANALOG_FULL : pwm_pkg::PERMIL_FULL;
		v = (val > full) ? full : val;
		w = (32'(v) * 32'(per)) / 32'(full);
		if (w[15:0] < minp)
			pulse_width = 16'h0000;
		else if ((per - w[15:0]) < minp)
			pulse_width = per;
		else
			pulse_width = w[15:0];
	endfunction

	assign width_nxt = pulse_width(out_val_in, period_in, fmt_analog_in, min_pulse_in);
	assign running_out = (state_r == ST_RUN);

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= ST_IDLE;
			cnt_r <= 16'h0000;
			width_r <= 16'h0000;
		end else if (!gate_in) begin
			state_r <= ST_IDLE;
			cnt_r <= 16'h0000;
		end else begin
			case (state_r)
				ST_IDLE: begin
					cnt_r <= 16'h0000;
					width_r <= width_nxt;
					state_r <= (delay_in == 16'h0000) ? ST_RUN : ST_DELAY;
				end
				ST_DELAY: begin
					if (tick_in) begin
						if (cnt_r == delay_in - 16'h0001) begin
							cnt_r <= 16'h0000;
							width_r <= width_nxt;
							state_r <= ST_RUN;
						end else begin
							cnt_r <= cnt_r + 16'h0001;
						end
					end
				end
				ST_RUN: begin
					if (tick_in) begin
						if (cnt_r >= period_in - 16'h0001) begin
							cnt_r <= 16'h0000;
							width_r <= width_nxt;
						end else begin
							cnt_r <= cnt_r + 16'h0001;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			pwm_out <= 1'b0;
		else
			pwm_out <= gate_in && (state_r == ST_RUN) && (cnt_r < width_r);
	end
endmodule

// ---- rtl/pwm_top.sv ----
// Purpose: Four-channel pulse width generator with APB register access.
// Assumes: APB3 slave, 32-bit data, 25 MHz core clock, no wait states.
// Notes:   Channel n registers sit at n times the channel stride.
// Notes on behaviour
// - Output repeating pulse/pause sequence per channel.
// - Counting function disabled while generating.
// - Per-mil format: width = value/1000 * period.
// - Analog format: width = value/27648 * period.
// - Time base 1 ms or 0.1 ms.
// - First pulse waits for on-delay.
// - On-delay 0 to 65535 units.
// - Each cycle exactly one period long; with on-delay 0 the first cycle is up to one unit short.
// - Period limits per base, default 20000.
// - Pulses or pauses below minimum are suppressed.
// - Minimum pulse limits, default 2.
// - No interrupts raised.
// - Software gate; internal gate state readable.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pwm_top (
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic [3:0]       pwm_out,
	output logic [3:0]       count_enable_out
);
	logic [3:0]  gate_r;
	logic [3:0]  base_ms_r;
	logic [3:0]  fmt_analog_r;
	logic [15:0] period_r   [4];
	logic [15:0] delay_r    [4];
	logic [15:0] min_pulse_r[4];
	logic [15:0] out_val_r  [4];
	logic [3:0]  running;
	logic        tick_fine;
	logic        tick_ms;
	logic        wr_en;
	logic [1:0]  sel_ch;
	logic [11:0] sel_ofs;
	logic        addr_ok;
	logic [15:0] wval;

	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	assign sel_ch  = paddr_in[6:5];
	assign sel_ofs = paddr_in & 12'h01F;
	assign addr_ok = (paddr_in[11:7] == 5'h00) && (paddr_in[1:0] == 2'b00) && (sel_ofs <= pwm_pkg::OFS_OUTVAL);
	assign wr_en   = psel_in && penable_in && pwrite_in && addr_ok;
	assign wval    = pwdata_in[15:0];
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in && penable_in && !addr_ok;

	pwm_tick_gen u_tick (
		.core_clk_in   (core_clk_in),
		.reset_n_in    (reset_n_in),
		.tick_fine_out (tick_fine),
		.tick_ms_out   (tick_ms)
	);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			pwm_channel u_ch (
				.core_clk_in   (core_clk_in),
				.reset_n_in    (reset_n_in),
				.tick_in       (base_ms_r[g] ? tick_ms : tick_fine),
				.gate_in       (gate_r[g]),
				.fmt_analog_in (fmt_analog_r[g]),
				.period_in     (period_r[g]),
				.delay_in      (delay_r[g]),
				.min_pulse_in  (min_pulse_r[g]),
				.out_val_in    (out_val_r[g]),
				.pwm_out       (pwm_out[g]),
				.running_out   (running[g])
			);
		end
	endgenerate

	// Counting on a channel runs only while its generator gate is closed.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			count_enable_out <= 4'hF;
		else
			count_enable_out <= ~gate_r;
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			gate_r <= 4'h0;
			base_ms_r <= 4'h0;
			fmt_analog_r <= 4'h0;
		end else if (wr_en && sel_ofs == pwm_pkg::OFS_CTRL) begin
			gate_r[sel_ch] <= pwdata_in[pwm_pkg::CTRL_GATE_BIT];
			base_ms_r[sel_ch] <= pwdata_in[pwm_pkg::CTRL_BASE_BIT];
			fmt_analog_r[sel_ch] <= pwdata_in[pwm_pkg::CTRL_FMT_BIT];
		end
	end

	// Written values are clamped into their legal range for the selected base and format.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < 4; i++) begin
				period_r[i] <= pwm_pkg::PERIOD_RST;
				delay_r[i] <= pwm_pkg::DELAY_RST;
				min_pulse_r[i] <= pwm_pkg::MINPULSE_RST;
				out_val_r[i] <= pwm_pkg::OUTVAL_RST;
			end
		end else if (wr_en) begin
			case (sel_ofs)
				pwm_pkg::OFS_PERIOD: begin
					period_r[sel_ch] <= clamp(wval, base_ms_r[sel_ch] ? pwm_pkg::PERIOD_MIN_MS
						: pwm_pkg::PERIOD_MIN_FINE, 16'hFFFF);
				end
				pwm_pkg::OFS_DELAY: begin
					delay_r[sel_ch] <= wval;
				end
				pwm_pkg::OFS_MINPULSE: begin
					min_pulse_r[sel_ch] <= clamp(wval, base_ms_r[sel_ch] ? 16'h0000 : pwm_pkg::MINP_MIN_FINE,
						{1'b0, period_r[sel_ch][15:1]});
				end
				pwm_pkg::OFS_OUTVAL: begin
					out_val_r[sel_ch] <= clamp(wval, 16'h0000, fmt_analog_r[sel_ch] ? pwm_pkg::ANALOG_FULL
						: pwm_pkg::PERMIL_FULL);
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is registered in the setup phase so it is ready in the access phase.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prdata_out <= 32'h00000000;
		end else if (psel_in && !penable_in) begin
			prdata_out <= 32'h00000000;
			if (addr_ok) begin
				case (sel_ofs)
					pwm_pkg::OFS_CTRL: begin
						prdata_out[pwm_pkg::CTRL_GATE_BIT] <= gate_r[sel_ch];
						prdata_out[pwm_pkg::CTRL_BASE_BIT] <= base_ms_r[sel_ch];
						prdata_out[pwm_pkg::CTRL_FMT_BIT] <= fmt_analog_r[sel_ch];
						prdata_out[pwm_pkg::CTRL_STATE_BIT] <= gate_r[sel_ch];
						prdata_out[pwm_pkg::CTRL_CNTOFF_BIT] <= running[sel_ch];
						prdata_out[pwm_pkg::CTRL_OUT_BIT] <= pwm_out[sel_ch];
					end
					pwm_pkg::OFS_PERIOD:   prdata_out[15:0] <= period_r[sel_ch];
					pwm_pkg::OFS_DELAY:    prdata_out[15:0] <= delay_r[sel_ch];
					pwm_pkg::OFS_MINPULSE: prdata_out[15:0] <= min_pulse_r[sel_ch];
					pwm_pkg::OFS_OUTVAL:   prdata_out[15:0] <= out_val_r[sel_ch];
					default:               prdata_out <= 32'h00000000;
				endcase
			end
		end
	end

	property p_count_off;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		gate_r[0] |=> !count_enable_out[0];
	endproperty
	a_count_off: assert property (p_count_off) else $error("count enabled while generating");

	property p_gate_closed_low;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!gate_r[0] |=> !pwm_out[0];
	endproperty
	a_gate_closed_low: assert property (p_gate_closed_low) else $error("output high with gate closed");

	property p_no_output_before_run;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!running[0] |=> !pwm_out[0];
	endproperty
	a_no_output_before_run: assert property (p_no_output_before_run) else $error("output during delay");

	property p_period_floor;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_PERIOD && sel_ch == 2'd0 && !base_ms_r[0]
			|=> period_r[0] >= pwm_pkg::PERIOD_MIN_FINE;
	endproperty
	a_period_floor: assert property (p_period_floor) else $error("period below fine floor");

	property p_minp_half;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		$rose(wr_en && sel_ofs == pwm_pkg::OFS_MINPULSE && sel_ch == 2'd0)
			|=> min_pulse_r[0] <= {1'b0, period_r[0][15:1]};
	endproperty
	a_minp_half: assert property (p_minp_half) else $error("min pulse above half period");

	property p_outval_range;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_OUTVAL && sel_ch == 2'd0 && !fmt_analog_r[0]
			|=> out_val_r[0] <= pwm_pkg::PERMIL_FULL;
	endproperty
	a_outval_range: assert property (p_outval_range) else $error("output value out of range");

	property p_gate_open_runs;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		$rose(gate_r[0]) && delay_r[0] == 16'h0000 |=> running[0];
	endproperty
	a_gate_open_runs: assert property (p_gate_open_runs) else $error("no start without delay");

	property p_slverr;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		psel_in && penable_in && paddr_in[11:7] != 5'h00 |-> pslverr_out;
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");

	// Channel 0 stands for all four channels, which share one implementation.
	property p_count_on_closed;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!gate_r[0] |=> count_enable_out[0];
	endproperty
	a_count_on_closed: assert property (p_count_on_closed) else $error("count off with gate closed");

	property p_run_needs_gate;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		running[0] |-> $past(gate_r[0]);
	endproperty
	a_run_needs_gate: assert property (p_run_needs_gate) else $error("running without open gate");

	property p_close_stops_run;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!gate_r[0] |=> !running[0];
	endproperty
	a_close_stops_run: assert property (p_close_stops_run) else $error("still running after close");

	property p_gate_write;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_CTRL && sel_ch == 2'd0
			|=> gate_r[0] == $past(pwdata_in[pwm_pkg::CTRL_GATE_BIT]);
	endproperty
	a_gate_write: assert property (p_gate_write) else $error("gate write lost");

	property p_base_write;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_CTRL && sel_ch == 2'd0
			|=> base_ms_r[0] == $past(pwdata_in[pwm_pkg::CTRL_BASE_BIT]);
	endproperty
	a_base_write: assert property (p_base_write) else $error("time base write lost");

	property p_fmt_write;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_CTRL && sel_ch == 2'd0
			|=> fmt_analog_r[0] == $past(pwdata_in[pwm_pkg::CTRL_FMT_BIT]);
	endproperty
	a_fmt_write: assert property (p_fmt_write) else $error("format write lost");

	property p_delay_write;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_DELAY && sel_ch == 2'd0 |=> delay_r[0] == $past(wval);
	endproperty
	a_delay_write: assert property (p_delay_write) else $error("on-delay write lost");

	property p_period_keep;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_PERIOD && sel_ch == 2'd0 && wval >= pwm_pkg::PERIOD_MIN_FINE
			|=> period_r[0] == $past(wval);
	endproperty
	a_period_keep: assert property (p_period_keep) else $error("legal period altered");

	property p_minp_floor;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_MINPULSE && sel_ch == 2'd0 && !base_ms_r[0]
			|=> min_pulse_r[0] >= pwm_pkg::MINP_MIN_FINE;
	endproperty
	a_minp_floor: assert property (p_minp_floor) else $error("min pulse below fine floor");

	property p_outval_keep;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_en && sel_ofs == pwm_pkg::OFS_OUTVAL && sel_ch == 2'd0 && wval <= pwm_pkg::PERMIL_FULL
			|=> out_val_r[0] == $past(wval);
	endproperty
	a_outval_keep: assert property (p_outval_keep) else $error("legal output value altered");

	property p_rd_state;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		psel_in && !penable_in && !pwrite_in && paddr_in == pwm_pkg::OFS_CTRL
			|=> prdata_out[pwm_pkg::CTRL_STATE_BIT] == $past(gate_r[0]);
	endproperty
	a_rd_state: assert property (p_rd_state) else $error("gate state read wrong");

	property p_rd_period;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		psel_in && !penable_in && !pwrite_in && paddr_in == pwm_pkg::OFS_PERIOD
			|=> prdata_out[15:0] == $past(period_r[0]);
	endproperty
	a_rd_period: assert property (p_rd_period) else $error("period read wrong");

	property p_rd_output;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		psel_in && !penable_in && !pwrite_in && paddr_in == pwm_pkg::OFS_CTRL
			|=> prdata_out[pwm_pkg::CTRL_OUT_BIT] == $past(pwm_out[0]);
	endproperty
	a_rd_output: assert property (p_rd_output) else $error("output state read wrong");

	property p_err_offset;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		psel_in && penable_in && paddr_in[4:0] > 5'h10 |-> pslverr_out;
	endproperty
	a_err_offset: assert property (p_err_offset) else $error("bad offset not flagged");

	property p_no_err_mapped;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		psel_in && penable_in && paddr_in == pwm_pkg::OFS_PERIOD |-> !pslverr_out;
	endproperty
	a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped access flagged");
endmodule

// ---- dv/actuator_model.sv ----
// Purpose: Actuator on one channel output; times its on and off phases.
// Assumes: The output is active high.
// Notes:   Lengths are whole core clock cycles of the last finished phase.
`timescale 1ns/1ps
module actuator_model (
	input  wire logic   core_clk_in,
	input  wire logic   reset_n_in,
	input  wire logic   drive_in,
	output logic [31:0] on_len_out,
	output logic [31:0] off_len_out,
	output logic [15:0] edges_out
);
	logic        last_r;
	logic [31:0] run_r;
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last_r <= 1'b0;
			run_r <= 32'h1;
			on_len_out <= 32'h0;
			off_len_out <= 32'h0;
			edges_out <= 16'h0;
		end else if (drive_in != last_r) begin
			last_r <= drive_in;
			run_r <= 32'h1;
			edges_out <= edges_out + 16'h1;
			if (last_r) begin
				on_len_out <= run_r;
			end else begin
				off_len_out <= run_r;
			end
		end else begin
			run_r <= run_r + 32'h1;
		end
	end
endmodule

// ---- dv/test_multi_channel_pwm_output.sv ----
// Purpose: Self-checking bench for the four-channel pulse width generator.
// Assumes: Zero-wait APB slave; 0.1 ms time base unit is 2500 clocks.
// Notes:   Phase lengths are allowed a few cycles of pipeline slack.
`timescale 1ns/1ps
module test_multi_channel_pwm_output;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  pwm;
	logic [3:0]  cnt_en;
	logic [31:0] on_len [4];
	logic [31:0] off_len [4];
	logic [15:0] edges [4];
	int          fail_count = 0;
	int          checks_done = 0;

	always #20 clk = ~clk;

	pwm_top DUT (.core_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .pwm_out(pwm), .count_enable_out(cnt_en));

	for (genvar g = 0; g < 4; g++) begin : gen_act
		actuator_model act (.core_clk_in(clk), .reset_n_in(rst_n), .drive_in(pwm[g]),
			.on_len_out(on_len[g]), .off_len_out(off_len[g]), .edges_out(edges[g]));
	end

	task automatic stop_test;
		$display("Mismatches %0d, checks %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic near(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if ((got + 32'd4 >= exp && got <= exp + 32'd4) !== 1'b1) begin
			fail_count++;
			$display("ERROR at %0t: length %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			stop_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] ch, input logic [11:0] ofs, output logic [31:0] q,
		output logic e);
		apb(1'b0, ch * pwm_pkg::CH_STRIDE + ofs, 32'h0, q, e);
	endtask

	task automatic wr(input logic [11:0] ch, input logic [11:0] ofs, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, ch * pwm_pkg::CH_STRIDE + ofs, d, q, e);
	endtask

	// Settings go in with the gate shut, then the gate opens last.
	task automatic cfg(input logic [11:0] ch, input logic [31:0] ctl, input logic [31:0] per,
		input logic [31:0] dly, input logic [31:0] val);
		wr(ch, pwm_pkg::OFS_CTRL, ctl);
		wr(ch, pwm_pkg::OFS_PERIOD, per);
		wr(ch, pwm_pkg::OFS_MINPULSE, 32'h2);
		wr(ch, pwm_pkg::OFS_DELAY, dly);
		wr(ch, pwm_pkg::OFS_OUTVAL, val);
		wr(ch, pwm_pkg::OFS_CTRL, ctl | 32'h1);
	endtask

	task automatic scen_reset;
		logic [31:0] q;
		logic        e;
		chk({28'h0, cnt_en}, 32'hF);
		chk({28'h0, pwm}, 32'h0);
		rd(0, pwm_pkg::OFS_PERIOD, q, e);
		chk(q, 32'h4E20);
		rd(0, pwm_pkg::OFS_MINPULSE, q, e);
		chk(q, 32'h2);
		rd(0, pwm_pkg::OFS_DELAY, q, e);
		chk(q, 32'h0);
		rd(0, pwm_pkg::OFS_CTRL, q, e);
		chk(q, 32'h0);
		wr(0, pwm_pkg::OFS_PERIOD, 32'h1);
		rd(0, pwm_pkg::OFS_PERIOD, q, e);
		chk(q, 32'h4);
		wr(0, pwm_pkg::OFS_MINPULSE, 32'h100);
		rd(0, pwm_pkg::OFS_MINPULSE, q, e);
		chk(q, 32'h2);
		wr(0, pwm_pkg::OFS_OUTVAL, 32'd2000);
		rd(0, pwm_pkg::OFS_OUTVAL, q, e);
		chk(q, 32'd1000);
		rd(0, 12'h014, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		apb(1'b0, 12'h080, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		wr(3, pwm_pkg::OFS_CTRL, 32'h2);
		rd(3, pwm_pkg::OFS_CTRL, q, e);
		chk(q & 32'h2, 32'h2);
		wr(3, pwm_pkg::OFS_PERIOD, 32'h1);
		rd(3, pwm_pkg::OFS_PERIOD, q, e);
		chk(q, 32'h1);
		wr(3, pwm_pkg::OFS_MINPULSE, 32'h0);
		rd(3, pwm_pkg::OFS_MINPULSE, q, e);
		chk(q, 32'h0);
		wr(3, pwm_pkg::OFS_CTRL, 32'h0);
	endtask

	task automatic scen_per_mil;
		logic [31:0] q;
		logic        e;
		int          n;
		cfg(0, 32'h0, 32'h4, 32'h2, 32'd500);
		n = 0;
		while (pwm[0] !== 1'b1 && n < 6000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 6000) begin
			fail_count++;
			stop_test();
		end
		chk({31'h0, n > 2500 && n < 5010}, 32'h1);
		chk({31'h0, cnt_en[0]}, 32'h0);
		rd(0, pwm_pkg::OFS_CTRL, q, e);
		chk(q & 32'h101, 32'h101);
		repeat (21000) @(posedge clk);
		near(on_len[0], 32'd5000);
		near(off_len[0], 32'd5000);
	endtask

	task automatic scen_formats;
		cfg(1, 32'h4, 32'h4, 32'h0, 32'd13824);
		cfg(2, 32'h0, 32'h4, 32'h0, 32'd250);
		cfg(3, 32'h0, 32'h4, 32'h0, 32'd750);
		repeat (21000) @(posedge clk);
		near(on_len[1], 32'd5000);
		near(off_len[1], 32'd5000);
		chk({16'h0, edges[2]}, 32'h0);
		chk({31'h0, pwm[3]}, 32'h1);
		chk({16'h0, edges[3]}, 32'h1);
	endtask

	task automatic scen_gate_close;
		logic [31:0] q;
		logic        e;
		int          n;
		n = 0;
		while (pwm[0] !== 1'b1 && n < 12000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 12000) begin
			fail_count++;
			stop_test();
		end
		wr(0, pwm_pkg::OFS_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		chk({31'h0, pwm[0]}, 32'h0);
		chk({31'h0, cnt_en[0]}, 32'h1);
		rd(0, pwm_pkg::OFS_CTRL, q, e);
		chk(q & 32'h100, 32'h0);
		// With no on-delay the first pulse follows the gate at once.
		wr(0, pwm_pkg::OFS_DELAY, 32'h0);
		wr(0, pwm_pkg::OFS_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk({31'h0, pwm[0]}, 32'h1);
	endtask

	initial begin
		#4000000;
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		scen_reset();
		scen_per_mil();
		scen_formats();
		scen_gate_close();
		stop_test();
	end
endmodule
